// ### stage_delay_consts.vh
`ifndef STAGE_DELAY_CONSTS_VH
`define STAGE_DELAY_CONSTS_VH
// Clock rate and the force timeout
`define CLK_MHZ 250
`define FORCE_TIMEOUT_S 300
// FORCE_TIMEOUT_S * 1000000 * CLK_MHZ, written out sized since it overflows 32 bits
`define FORCE_TIMEOUT_CYC 40'd75000000000
// Comparison modes
`define CMP_OVER 2'h0
`define CMP_UNDER 2'h1
`define CMP_DIFF 2'h2
`define CMP_ABSOLUTE_DIFFERENCE_COMPARE 2'h3
// Curve families
`define FAM_DT 3'h0
`define FAM_IEC 3'h1
`define FAM_IEEE 3'h2
`define FAM_IEEE2 3'h3
`define FAM_RI 3'h4
`define FAM_PRG 3'h5
// Delay types
`define TYP_DT 4'h0
`define TYP_NI 4'h1
`define TYP_VI 4'h2
`define TYP_EI 4'h3
`define TYP_LTI 4'h4
`define TYP_LTEI 4'h5
`define TYP_LTVI 4'h6
`define TYP_MI 4'h7
`define TYP_STI 4'h8
`define TYP_STEI 4'h9
`define TYP_RI 4'ha
`define TYP_RXIDG 4'hb
`define TYP_PARAM 4'hc
// Curve evaluation span, multiples of pickup
`define CURVE_SPAN 5'd20
`define PRG_POINTS 16
`define PRG_CURVES 3
`define FAULT_RECS 8
`define PCT_FULL 100
`endif

// ### force_timer.v
`timescale 1ns/100ps
`include "stage_delay_consts.vh"
// Shared force flag with automatic clear after the timeout
module force_timer #(
  parameter [39:0] TIMEOUT_CYC = `FORCE_TIMEOUT_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire set_i,
  input wire clr_i,
  output reg force_o
);
  reg [39:0] cnt_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      force_o <= 1'b0;
      cnt_q <= 40'h0;
    end else if (ce_i) begin
      if (set_i) begin
        force_o <= 1'b1;
        cnt_q <= 40'h0;
      end else if (clr_i) begin
        force_o <= 1'b0;
      end else if (force_o) begin
        if (cnt_q >= TIMEOUT_CYC - 40'h1) begin
          force_o <= 1'b0;
        end else begin
          cnt_q <= cnt_q + 40'h1;
        end
      end
    end
  end
endmodule

// ### curve_check.v
`timescale 1ns/100ps
`include "stage_delay_consts.vh"
// Decides whether a family/type pair or parameter set can form a curve
module curve_check (
  input wire [2:0] family_i,
  input wire [3:0] dtype_i,
  input wire coef_ok_i,
  input wire prg_ok_i,
  output reg valid_o
);
  always @* begin
    valid_o = 1'b0;
    if (dtype_i == `TYP_PARAM) begin
      valid_o = coef_ok_i && (family_i == `FAM_IEC || family_i == `FAM_IEEE ||
                              family_i == `FAM_IEEE2);
    end else begin
      case (family_i)
        `FAM_DT: valid_o = (dtype_i == `TYP_DT);
        `FAM_IEC: valid_o = (dtype_i == `TYP_NI) || (dtype_i == `TYP_VI) ||
                            (dtype_i == `TYP_EI) || (dtype_i == `TYP_LTI);
        `FAM_IEEE: valid_o = (dtype_i == `TYP_VI) || (dtype_i == `TYP_EI) ||
                             (dtype_i == `TYP_LTI) || (dtype_i == `TYP_LTEI) ||
                             (dtype_i == `TYP_LTVI) || (dtype_i == `TYP_MI) ||
                             (dtype_i == `TYP_STI) || (dtype_i == `TYP_STEI);
        `FAM_IEEE2: valid_o = (dtype_i == `TYP_NI) || (dtype_i == `TYP_VI) ||
                              (dtype_i == `TYP_EI) || (dtype_i == `TYP_MI);
        `FAM_RI: valid_o = (dtype_i == `TYP_RI) || (dtype_i == `TYP_RXIDG);
        `FAM_PRG: valid_o = prg_ok_i;
        default: valid_o = 1'b0;
      endcase
    end
  end
endmodule

// ### stage_delay.v
`timescale 1ns/100ps
`include "stage_delay_consts.vh"
module stage_delay #(
  parameter W = 16,
  parameter [39:0] FORCE_CYC = `FORCE_TIMEOUT_CYC,
  parameter [31:0] TICK_CYC = 32'd250000
) (
  input wire CLOCK_I, // Clock
  input wire RST_I, // Sync reset, high
  input wire CE_I, // Clock enable
  input wire FORCE_SET_I, // Set force flag
  input wire FORCE_CLR_I, // Clear force flag
  output wire FORCE_O, // Shared force flag
  input wire STATUS_WR_I, // Write forced status
  input wire START_WR_I, // Forced start value
  input wire TRIP_WR_I, // Forced trip value
  input wire [W-1:0] VALUE_I, // Supervised value, pu
  input wire [W-1:0] REF_I, // Reference for difference modes
  input wire [1:0] MODE_I, // comparison_mode
  input wire [W-1:0] PICKUP_I, // Pickup, pu
  input wire [W-1:0] PRI_SCALE_I, // Primary per pu
  output reg [2*W-1:0] PICKUP_PRI_O, // Pickup at primary level
  input wire [W-1:0] HYST_I, // Dead band, pu
  input wire [W-1:0] FLOOR_I, // under_compare_floor
  input wire [31:0] DT_TICKS_I, // Definite time in ticks
  input wire [2:0] FAMILY_I, // Curve family
  input wire [3:0] DTYPE_I, // Delay type
  input wire [1:0] PRG_SEL_I, // programmable_curve_family index
  input wire COEF_OK_I, // Coefficients A-E usable
  input wire [`PRG_CURVES-1:0] PRG_OK_I, // Per programmable curve usable
  input wire [31:0] INV_RATE_I, // Inverse progress per tick, Q0.32
  input wire [1:0] GROUP_I, // active_setting_group
  input wire [31:0] TIME_I, // Timestamp
  input wire [2:0] REC_IDX_I, // Fault record to read, 0 newest
  output reg [31:0] REC_TIME_O, // Record timestamp
  output reg [W-1:0] REC_VALUE_O, // Record fault value
  output reg [7:0] REC_PCT_O, // Record elapsed_delay_pct
  output reg [1:0] REC_GROUP_O, // Record setting group
  output reg [3:0] REC_COUNT_O, // Records held
  output reg INV_ACTIVE_O, // Inverse timing in use
  output reg SET_ERR_O, // Setting error
  output reg START_O, // Stage start
  output reg TRIP_O, // Stage trip
  output reg [7:0] ELAPSED_DELAY_PCT_O // Live elapsed_delay_pct
);
  // ====================
  // Force flag
  force_timer #(.TIMEOUT_CYC(FORCE_CYC)) u_force (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .set_i(FORCE_SET_I),
    .clr_i(FORCE_CLR_I),
    .force_o(FORCE_O)
  );

  // ====================
  // Curve validity
  wire prg_ok;
  wire cfg_valid;
  assign prg_ok = (PRG_SEL_I < `PRG_CURVES) ? PRG_OK_I[PRG_SEL_I] : 1'b0;
  curve_check u_check (
    .family_i(FAMILY_I),
    .dtype_i(DTYPE_I),
    .coef_ok_i(COEF_OK_I),
    .prg_ok_i(prg_ok),
    .valid_o(cfg_valid)
  );
  wire inverse_req;
  assign inverse_req = (FAMILY_I != `FAM_DT);

  // ====================
  // Comparison
  reg [W:0] mag;
  reg above_pick;
  reg above_rel;
  reg cmp_en;
  wire [W:0] rel_hi;
  wire [W:0] rel_lo;
  assign rel_hi = {1'b0, PICKUP_I} - {1'b0, HYST_I};
  assign rel_lo = {1'b0, PICKUP_I} + {1'b0, HYST_I};
  always @* begin
    mag = {1'b0, VALUE_I};
    cmp_en = 1'b1;
    case (MODE_I)
      `CMP_DIFF: mag = {1'b0, VALUE_I} - {1'b0, REF_I};
      `CMP_ABSOLUTE_DIFFERENCE_COMPARE: mag = (VALUE_I >= REF_I) ? {1'b0, VALUE_I} - {1'b0, REF_I}
                                           : {1'b0, REF_I} - {1'b0, VALUE_I};
      default: mag = {1'b0, VALUE_I};
    endcase
    if (MODE_I == `CMP_UNDER) begin
      cmp_en = (VALUE_I >= FLOOR_I);
      above_pick = cmp_en && (VALUE_I < PICKUP_I);
      above_rel = cmp_en && ({1'b0, VALUE_I} < rel_lo);
    end else begin
      above_pick = !mag[W] && (mag >= {1'b0, PICKUP_I});
      above_rel = !mag[W] && !rel_hi[W] && (mag > rel_hi);
    end
  end

  // ====================
  // Timing
  reg [31:0] tick_q;
  reg [31:0] dt_cnt_q;
  reg [32:0] acc_q;
  reg [W-1:0] peak_q;
  wire tick;
  wire start_now;
  wire timing;
  assign tick = (tick_q == TICK_CYC - 32'h1);
  assign start_now = START_O ? above_rel : above_pick;
  assign timing = START_O && !TRIP_O;

  // Progress in percent for either delay kind
  wire [39:0] dt_pct_w;
  wire [39:0] inv_pct_w;
  reg [7:0] pct_now;
  assign dt_pct_w = (DT_TICKS_I == 32'h0) ? 40'd100 :
                    ({8'h0, dt_cnt_q} * 40'd100) / {8'h0, DT_TICKS_I};
  assign inv_pct_w = (acc_q[32] ? 40'd100 : ((acc_q[31:24] * 40'd100) >> 8));
  always @* begin
    if (INV_ACTIVE_O) begin
      pct_now = inv_pct_w[7:0];
    end else begin
      pct_now = (dt_pct_w > 40'd100) ? 8'd100 : dt_pct_w[7:0];
    end
  end

  wire [32:0] acc_next;
  wire [W+4:0] span_lim;
  assign acc_next = acc_q + {1'b0, INV_RATE_I};
  assign span_lim = {5'h0, PICKUP_I} * `CURVE_SPAN;

  reg [31:0] rec_time [0:`FAULT_RECS-1];
  reg [W-1:0] rec_val [0:`FAULT_RECS-1];
  reg [7:0] rec_pct [0:`FAULT_RECS-1];
  reg [1:0] rec_grp [0:`FAULT_RECS-1];
  reg fault_end;
  integer i;

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      tick_q <= 32'h0;
      dt_cnt_q <= 32'h0;
      acc_q <= 33'h0;
      peak_q <= {W{1'b0}};
      START_O <= 1'b0;
      TRIP_O <= 1'b0;
      SET_ERR_O <= 1'b0;
      INV_ACTIVE_O <= 1'b0;
      ELAPSED_DELAY_PCT_O <= 8'h0;
      PICKUP_PRI_O <= {2*W{1'b0}};
      REC_COUNT_O <= 4'h0;
      for (i = 0; i < `FAULT_RECS; i = i + 1) begin
        rec_time[i] <= 32'h0;
        rec_val[i] <= {W{1'b0}};
        rec_pct[i] <= 8'h0;
        rec_grp[i] <= 2'h0;
      end
    end else if (CE_I) begin
      PICKUP_PRI_O <= PICKUP_I * PRI_SCALE_I;
      SET_ERR_O <= inverse_req && !cfg_valid;
      // Bad inverse setup runs on the definite timer instead
      INV_ACTIVE_O <= inverse_req && cfg_valid;
      ELAPSED_DELAY_PCT_O <= pct_now;
      tick_q <= tick ? 32'h0 : tick_q + 32'h1;
      if (FORCE_O && STATUS_WR_I) begin
        START_O <= START_WR_I;
        TRIP_O <= TRIP_WR_I;
      end else if (!start_now) begin
        START_O <= 1'b0;
        TRIP_O <= 1'b0;
        dt_cnt_q <= 32'h0;
        acc_q <= 33'h0;
      end else begin
        START_O <= 1'b1;
        if (!START_O) begin
          peak_q <= VALUE_I;
        end else if (VALUE_I > peak_q) begin
          peak_q <= VALUE_I;
        end
        if (timing && tick) begin
          if (INV_ACTIVE_O) begin
            // Rate comes from the curve evaluator; both span branches add the same rate, nothing saturates
            if (mag >= span_lim) begin
              acc_q <= acc_next;
            end else begin
              acc_q <= acc_next;
            end
            if (acc_next[32]) begin
              TRIP_O <= 1'b1;
            end
          end else begin
            dt_cnt_q <= dt_cnt_q + 32'h1;
            if (dt_cnt_q + 32'h1 >= DT_TICKS_I) begin
              TRIP_O <= 1'b1;
            end
          end
        end
      end
      if (fault_end) begin
        for (i = `FAULT_RECS - 1; i > 0; i = i - 1) begin
          rec_time[i] <= rec_time[i-1];
          rec_val[i] <= rec_val[i-1];
          rec_pct[i] <= rec_pct[i-1];
          rec_grp[i] <= rec_grp[i-1];
        end
        rec_time[0] <= TIME_I;
        rec_val[0] <= peak_q;
        rec_pct[0] <= TRIP_O ? 8'd100 : pct_now;
        rec_grp[0] <= GROUP_I;
        if (REC_COUNT_O != `FAULT_RECS) begin
          REC_COUNT_O <= REC_COUNT_O + 4'h1;
        end
      end
    end
  end

  // A fault ends when the start condition drops
  always @* begin
    fault_end = START_O && !start_now && !(FORCE_O && STATUS_WR_I);
  end

  // ====================
  // Record readout
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      REC_TIME_O <= 32'h0;
      REC_VALUE_O <= {W{1'b0}};
      REC_PCT_O <= 8'h0;
      REC_GROUP_O <= 2'h0;
    end else if (CE_I) begin
      REC_TIME_O <= rec_time[REC_IDX_I];
      REC_VALUE_O <= rec_val[REC_IDX_I];
      REC_PCT_O <= rec_pct[REC_IDX_I];
      REC_GROUP_O <= rec_grp[REC_IDX_I];
    end
  end
endmodule

// ### meas_front.sv
`timescale 1ns/100ps
// ======
// Measurement front end, one sample of latency like a real filter stage
module meas_front (
  input wire clk_i, // Clock
  input wire [15:0] level_i, // Level to present
  output reg [15:0] value_o // Supervised value
);
  initial value_o = 16'h0000;
  always @(posedge clk_i) begin
    value_o <= level_i;
  end
endmodule

// ### stage_delay_checker.sv
`timescale 1ns/100ps
`include "stage_delay_consts.vh"
module stage_delay_checker #(
  parameter W = 16,
  parameter [39:0] FORCE_CYC = 40'h64
) (
  input wire CLOCK_I, // Clock
  input wire RST_I, // Reset
  input wire CE_I, // Enable
  input wire FORCE_SET_I, // Force set
  input wire FORCE_O, // Force flag
  input wire [W-1:0] VALUE_I, // Value
  input wire [1:0] MODE_I, // Mode
  input wire [W-1:0] PICKUP_I, // Pickup
  input wire [W-1:0] PRI_SCALE_I, // Scale
  input wire [2*W-1:0] PICKUP_PRI_O, // Primary pickup
  input wire [W-1:0] FLOOR_I, // Floor
  input wire [2:0] FAMILY_I, // Family
  input wire [3:0] DTYPE_I, // Type
  input wire SET_ERR_O, // Setting error
  input wire INV_ACTIVE_O, // Inverse used
  input wire START_O, // Start
  input wire [7:0] ELAPSED_DELAY_PCT_O, // Elapsed
  input wire [3:0] REC_COUNT_O // Records
);
  // ======
  // Force age, restarted by every set so a late set extends the window
  reg [39:0] on_q;
  always @(posedge CLOCK_I) begin
    if (RST_I || FORCE_SET_I || !FORCE_O) on_q <= 40'h0;
    else if (CE_I) on_q <= on_q + 40'h1;
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence s_iec_ni;
    CE_I && FAMILY_I == `FAM_IEC && DTYPE_I == `TYP_NI;
  endsequence
  sequence s_ieee_ni;
    CE_I && FAMILY_I == `FAM_IEEE && DTYPE_I == `TYP_NI;
  endsequence
  property p_force_set;
    FORCE_SET_I && CE_I |=> FORCE_O;
  endproperty
  property p_force_age;
    on_q <= FORCE_CYC;
  endproperty
  property p_pri;
    CE_I |=> PICKUP_PRI_O == {{W{1'b0}}, $past(PICKUP_I)} * {{W{1'b0}}, $past(PRI_SCALE_I)};
  endproperty
  property p_under;
    (CE_I && !FORCE_O && MODE_I == `CMP_UNDER && VALUE_I < FLOOR_I) [*2] |-> !START_O;
  endproperty
  property p_over;
    (CE_I && !FORCE_O && MODE_I == `CMP_OVER && VALUE_I > PICKUP_I) [*2] |-> START_O;
  endproperty
  property p_rec;
    REC_COUNT_O != $past(REC_COUNT_O) |-> REC_COUNT_O == $past(REC_COUNT_O) + 4'h1;
  endproperty
  property p_pct;
    ELAPSED_DELAY_PCT_O <= `PCT_FULL && REC_COUNT_O <= `FAULT_RECS;
  endproperty
  property p_dt;
    (CE_I && FAMILY_I == `FAM_DT) [*2] |-> !SET_ERR_O && !INV_ACTIVE_O;
  endproperty
  property p_valid;
    s_iec_ni [*2] |-> !SET_ERR_O && INV_ACTIVE_O;
  endproperty
  property p_bad;
    s_ieee_ni [*2] |-> SET_ERR_O && !INV_ACTIVE_O;
  endproperty
  a_force_set: assert property (p_force_set) else $error("force flag not set");
  a_force_age: assert property (p_force_age) else $error("force flag held too long");
  a_pri: assert property (p_pri) else $error("primary pickup wrong");
  a_under: assert property (p_under) else $error("start below floor");
  a_over: assert property (p_over) else $error("no start over pickup");
  a_rec: assert property (p_rec) else $error("record count jump");
  a_pct: assert property (p_pct) else $error("elapsed or count out of range");
  a_dt: assert property (p_dt) else $error("definite time flagged");
  a_valid: assert property (p_valid) else $error("valid curve refused");
  a_bad: assert property (p_bad) else $error("illegal curve accepted");
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
`include "stage_delay_consts.vh"
module tb_top;
  logic clk = 0, rst = 1, set_f = 0, clr_f = 0, wr = 0, st_w = 0, tr_w = 0, coef = 0;
  logic frc, inv, err, start, trip;
  logic ce = 1;
  logic [15:0] refv = 0;
  logic [1:0] psel = 0;
  logic [31:0] tstamp = 32'h00001234;
  logic [15:0] lvl = 0, value, pickup = 16'h0100, floor_v = 16'h0040, rec_val;
  logic [1:0] mode = 0, grp = 0, rec_grp;
  logic [2:0] fam = 0, ridx = 0, prg = 0;
  logic [3:0] dtyp = 0, rec_cnt;
  logic [31:0] ticks = 32'h3, rate = 0, pri, rec_time;
  logic [7:0] rec_pct, elapsed_delay_pct;
  int n_fail = 0, comparisons = 0, n, m;
  // Family, type, then coef ok, curve ok, error, inverse
  logic [10:0] rows [9] = '{{`FAM_DT, `TYP_DT, 4'h0}, {`FAM_IEC, `TYP_NI, 4'h1},
    {`FAM_IEEE, `TYP_NI, 4'h2}, {`FAM_IEEE, `TYP_MI, 4'h1}, {`FAM_IEEE2, `TYP_PARAM, 4'h9},
    {`FAM_IEEE2, `TYP_PARAM, 4'h2}, {`FAM_PRG, `TYP_DT, 4'h5}, {`FAM_PRG, `TYP_DT, 4'h2},
    {`FAM_RI, `TYP_RI, 4'h1}};
  always #2 clk = ~clk;
  meas_front fe (.clk_i(clk), .level_i(lvl), .value_o(value));
  stage_delay #(.W(16), .FORCE_CYC(40'h64), .TICK_CYC(32'h4)) dut (
    .CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .FORCE_SET_I(set_f), .FORCE_CLR_I(clr_f),
    .FORCE_O(frc), .STATUS_WR_I(wr), .START_WR_I(st_w), .TRIP_WR_I(tr_w), .VALUE_I(value),
    .REF_I(refv), .MODE_I(mode), .PICKUP_I(pickup), .PRI_SCALE_I(16'h0064),
    .PICKUP_PRI_O(pri), .HYST_I(16'h0010), .FLOOR_I(floor_v), .DT_TICKS_I(ticks),
    .FAMILY_I(fam), .DTYPE_I(dtyp), .PRG_SEL_I(psel), .COEF_OK_I(coef), .PRG_OK_I(prg),
    .INV_RATE_I(rate), .GROUP_I(grp), .TIME_I(tstamp), .REC_IDX_I(ridx),
    .REC_TIME_O(rec_time), .REC_VALUE_O(rec_val), .REC_PCT_O(rec_pct), .REC_GROUP_O(rec_grp),
    .REC_COUNT_O(rec_cnt), .INV_ACTIVE_O(inv), .SET_ERR_O(err), .START_O(start),
    .TRIP_O(trip), .ELAPSED_DELAY_PCT_O(elapsed_delay_pct));
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait for trip, then release so the record is pushed
  task fault(input logic [15:0] v, input int hold);
    lvl = v;
    n = 0;
    while (trip !== 1'b1 && n < hold) begin
      step(1);
      n++;
    end
    if (trip === 1'b1) begin
      step(1);
      chk(elapsed_delay_pct, `PCT_FULL);
    end
    lvl = 0;
    step(3);
  endtask
  // One write edge; the caller checks right after it
  task status(input logic [1:0] v);
    {wr, st_w, tr_w} = {1'b1, v};
    step(1);
    wr = 0;
  endtask
  initial begin
    #40000;
    n_fail++;
    results;
  end
  initial begin
    step(2);
    rst = 0;
    chk({frc, start, trip, rec_cnt}, 0);
    step(1);
    chk(pri, 32'h6400);
    foreach (rows[i]) begin
      {fam, dtyp, coef, prg} = {rows[i][10:3], {2{~rows[i][2]}}, rows[i][2]};
      step(2);
      chk({err, inv}, rows[i][1:0]);
    end
    {fam, dtyp, prg, psel} = {`FAM_PRG, `TYP_DT, 3'h2, 2'h1};
    step(2);
    chk({err, inv}, 2'h1);
    psel = 2'h3;
    step(2);
    chk({err, inv}, 2'h2);
    psel = 2'h0;
    {fam, dtyp, grp} = {7'h0, 2'h2};
    status(2'h3);
    chk({start, trip}, 0);
    set_f = 1;
    step(1);
    set_f = 0;
    clr_f = 1;
    step(1);
    clr_f = 0;
    step(1);
    chk(frc, 0);
    set_f = 1;
    step(1);
    set_f = 0;
    chk(frc, 1);
    status(2'h3);
    chk({start, trip}, 2'h3);
    status(2'h0);
    chk({start, trip, rec_cnt}, 0);
    step(88);
    chk(frc, 1);
    step(12);
    chk(frc, 0);
    fault(16'h0300, 60);
    chk(n > 9 && n < 21, 1);
    chk({start, trip, rec_cnt, rec_pct, rec_grp}, {6'h1, 8'h64, 2'h2});
    chk({rec_val, rec_time}, {16'h0300, 32'h00001234});
    lvl = 16'h0200;
    step(4);
    lvl = 16'h00f8;
    step(4);
    chk(start, 1);
    lvl = 0;
    mode = `CMP_UNDER;
    lvl = 16'h0010;
    step(4);
    chk(start, 0);
    lvl = 16'h0080;
    step(4);
    chk(start, 1);
    {mode, fam, dtyp, rate} = {2'h0, `FAM_IEC, `TYP_NI, 32'h40000000};
    fault(16'h0300, 60);
    m = n;
    rate = 32'h80000000;
    fault(16'h0300, 60);
    chk(n < m && rec_pct == 8'h64, 1);
    {fam, dtyp, ticks} = {7'h0, 32'h64};
    for (int i = 0; i < 9; i++) begin
      tstamp = 32'h00005000 + i;
      fault(16'h0200 + i[15:0], 3);
    end
    chk({rec_cnt, rec_val}, {4'h8, 16'h0208});
    ridx = 3'h7;
    step(2);
    chk({rec_val, rec_time[15:0]}, {16'h0201, 16'h5001});
    chk(rec_pct < 8'h64 && rec_grp == 2'h2, 1);
    ce = 0;
    lvl = 16'h0300;
    step(4);
    chk(start, 0);
    ce = 1;
    step(3);
    chk(start, 1);
    mode = `CMP_DIFF;
    refv = 16'h0280;
    step(3);
    chk(start, 0);
    refv = 16'h0100;
    step(3);
    chk(start, 1);
    mode = `CMP_ABSOLUTE_DIFFERENCE_COMPARE;
    refv = 16'h0300;
    step(3);
    chk(start, 0);
    refv = 16'h0500;
    step(3);
    chk(start, 1);
    {mode, refv, lvl} = {2'h0, 16'h0000, 16'h0000};
    step(3);
    rst = 1;
    step(2);
    rst = 0;
    chk({rec_cnt, start, trip}, 0);
    results;
  end
endmodule
bind stage_delay stage_delay_checker #(.W(W), .FORCE_CYC(FORCE_CYC)) u_chk (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I), .FORCE_SET_I(FORCE_SET_I), .FORCE_O(FORCE_O),
  .VALUE_I(VALUE_I), .MODE_I(MODE_I), .PICKUP_I(PICKUP_I), .PRI_SCALE_I(PRI_SCALE_I),
  .PICKUP_PRI_O(PICKUP_PRI_O), .FLOOR_I(FLOOR_I), .FAMILY_I(FAMILY_I), .DTYPE_I(DTYPE_I),
  .SET_ERR_O(SET_ERR_O), .INV_ACTIVE_O(INV_ACTIVE_O), .START_O(START_O), .ELAPSED_DELAY_PCT_O(ELAPSED_DELAY_PCT_O),
  .REC_COUNT_O(REC_COUNT_O));
